// ==== hw/frc_defs.vh ====
// offsets, field positions, reset values and strap codes of the flag block
// assumes inclusion by frc_top.v only
`ifndef FRC_DEFS_VH
`define FRC_DEFS_VH

// register byte offsets
`define FRC_CFG_OFS 8'h00
`define FRC_FLAG_OFS 8'h04
`define FRC_EOFS_OFS 8'h08
`define FRC_FOFS_OFS 8'h0c
`define FRC_IST_OFS 8'h10
`define FRC_IMSK_OFS 8'h14
`define FRC_CNT_OFS 8'h18

// configuration register fields
`define FRC_CFG_FALL_THROUGH_SELECT 0
`define FRC_CFG_BORD 1
`define FRC_CFG_PAR 2
`define FRC_CFG_PLD 3
`define FRC_CFG_WW 4
`define FRC_CFG_RW 6
`define FRC_CFG_DIDX 8

// port width codes
`define FRC_W36 2'h0
`define FRC_W18 2'h1
`define FRC_W9 2'h2

// interrupt event bits
`define FRC_EV_EMPTY 0
`define FRC_EV_FULL 1
`define FRC_EV_HALF 2
`define FRC_EV_AEMP 3
`define FRC_EV_AFUL 4
`define FRC_EV_DROP 5
`define FRC_EV_MRS 6
`define FRC_NEV 7

// reset values
`define FRC_IMSK_RST 7'h00
`define FRC_RDATA_RST 32'h00000000

// the eight default offsets
`define FRC_DOFS0 11'h007
`define FRC_DOFS1 11'h00f
`define FRC_DOFS2 11'h01f
`define FRC_DOFS3 11'h03f
`define FRC_DOFS4 11'h07f
`define FRC_DOFS5 11'h0ff
`define FRC_DOFS6 11'h1ff
`define FRC_DOFS7 11'h3ff

`endif

// ==== hw/frc_top.v ====
// strap capture, offset registers and status flags of a 36-bit fifo
// assumes all pins synchronous to clk_sys and an ahb-lite master
// Operation
// - port widths follow all three width straps
// - width strap table maps to five configurations
// - byte order low big, high little; strap is only stored as cfg bit 1, no data is reordered
// - narrow write port ignores upper data lines
// - standard mode: empty output means no words
// - fall-through: output shows word presented
// - standard mode: full output means no space
// - fall-through: input ready means space left
// - two selects plus load pick default offset
// - dual pin at reset selects timing mode
// - after reset dual pin is serial input
// - half flag compares count with half capacity
// - parity strap low separate, high interspersed
// - parity placement only affects parallel offset loads
// - parity bit positions per placement mode
// - load pin at reset picks programming method
// - active load steers cycles to offsets
// - serial enable with load shifts one bit
`timescale 1ns/1ps
`include "frc_defs.vh"

module frc_top #(
  parameter DEPTH = 1024,
  parameter CW = 11
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // straps and control pins
  input wire master_reset_n,
  input wire width_match_enable,
  input wire input_width_select,
  input wire output_width_select,
  input wire byte_order_select,
  input wire default_offset_sel_lo,
  input wire default_offset_sel_hi,
  input wire fall_through_select,
  input wire parity_placement_select,
  input wire offset_access_enable_n,
  input wire serial_load_enable_n,
  input wire write_enable_n,
  input wire read_enable_n,
  input wire [35:0] write_data_in,
  // flags
  output reg empty_flag_n,
  output reg full_flag_n,
  output reg half_full_flag_n,
  output reg almost_empty_flag_n,
  output reg almost_full_flag_n,
  output reg irq
);

  localparam [CW-1:0] DEPTH_C = DEPTH;
  localparam [CW-1:0] HALF_C = DEPTH / 2;
  localparam [CW-1:0] ONE_C = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture
  reg fall_through_select_r;
  reg bord_r;
  reg par_r;
  reg pld_r;
  reg [1:0] ww_r;
  reg [1:0] rw_r;
  reg [2:0] didx_r;
  reg mrs_d_r;
  reg [1:0] ww_nxt;
  reg [1:0] rw_nxt;

  always @* begin
    ww_nxt = `FRC_W36;
    rw_nxt = `FRC_W36;
    if (width_match_enable) begin
      case ({input_width_select, output_width_select})
        2'h0: rw_nxt = `FRC_W18;
        2'h1: rw_nxt = `FRC_W9;
        2'h2: ww_nxt = `FRC_W18;
        2'h3: ww_nxt = `FRC_W9;
        default: rw_nxt = `FRC_W36;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fall_through_select_r <= 1'b0;
      bord_r <= 1'b0;
      par_r <= 1'b0;
      pld_r <= 1'b0;
      ww_r <= `FRC_W36;
      rw_r <= `FRC_W36;
      didx_r <= 3'h0;
      mrs_d_r <= 1'b1;
    end else begin
      mrs_d_r <= master_reset_n;
      if (!master_reset_n) begin
        fall_through_select_r <= fall_through_select;
        bord_r <= byte_order_select;
        par_r <= parity_placement_select;
        pld_r <= ~offset_access_enable_n;
        ww_r <= ww_nxt;
        rw_r <= rw_nxt;
        didx_r <= {offset_access_enable_n, default_offset_sel_hi,
                   default_offset_sel_lo};
      end
    end
  end

  wire mrs_done = master_reset_n & ~mrs_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // default offset table and parallel offset extraction
  reg [CW-1:0] dofs;
  always @* begin
    case (didx_r)
      3'h0: dofs = `FRC_DOFS0;
      3'h1: dofs = `FRC_DOFS1;
      3'h2: dofs = `FRC_DOFS2;
      3'h3: dofs = `FRC_DOFS3;
      3'h4: dofs = `FRC_DOFS4;
      3'h5: dofs = `FRC_DOFS5;
      3'h6: dofs = `FRC_DOFS6;
      default: dofs = `FRC_DOFS7;
    endcase
  end

  reg [35:0] din_m;
  reg [31:0] pval;
  always @* begin
    case (ww_r)
      `FRC_W18: din_m = {18'h00000, write_data_in[17:0]};
      `FRC_W9: din_m = {27'h0000000, write_data_in[8:0]};
      default: din_m = write_data_in;
    endcase
    if (par_r) begin
      pval = {din_m[34:27], din_m[25:18], din_m[16:9], din_m[7:0]};
    end else begin
      pval = din_m[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset registers
  reg [CW-1:0] eofs_r;
  reg [CW-1:0] fofs_r;
  reg psel_r;
  wire ld_act = ~offset_access_enable_n & master_reset_n;
  wire ser_ld = ld_act & ~serial_load_enable_n & ~pld_r;
  wire par_ld = ld_act & ~write_enable_n & pld_r;

  always @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      eofs_r <= `FRC_DOFS0;
      fofs_r <= `FRC_DOFS0;
      psel_r <= 1'b0;
    end else if (!master_reset_n) begin
      eofs_r <= dofs;
      fofs_r <= dofs;
      psel_r <= 1'b0;
    end else if (ser_ld) begin
      eofs_r <= {eofs_r[CW-2:0], fofs_r[CW-1]};
      fofs_r <= {fofs_r[CW-2:0], fall_through_select};
    end else if (par_ld) begin
      psel_r <= ~psel_r;
      if (psel_r) begin
        fofs_r <= pval[CW-1:0];
      end else begin
        eofs_r <= pval[CW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word accounting with narrow port packing
  reg [CW-1:0] cnt_r;
  reg ov_r;
  reg [1:0] wsub_r;
  reg [1:0] rsub_r;
  reg [1:0] wlast;
  reg [1:0] rlast;

  always @* begin
    case (ww_r)
      `FRC_W18: wlast = 2'h1;
      `FRC_W9: wlast = 2'h3;
      default: wlast = 2'h0;
    endcase
    case (rw_r)
      `FRC_W18: rlast = 2'h1;
      `FRC_W9: rlast = 2'h3;
      default: rlast = 2'h0;
    endcase
  end

  wire run = master_reset_n & offset_access_enable_n;
  wire full_now = (cnt_r == DEPTH_C);
  wire wr_try = run & ~write_enable_n;
  wire wr_ok = wr_try & ~full_now;
  wire wr_word = wr_ok & (wsub_r == wlast);
  wire rd_avail = fall_through_select_r ? ov_r : (cnt_r != {CW{1'b0}});
  wire rd_ok = run & ~read_enable_n & rd_avail;
  wire rd_word = rd_ok & (rsub_r == rlast);
  wire pop = fall_through_select_r ? ((cnt_r != {CW{1'b0}}) & (~ov_r | rd_word)) : rd_word;

  reg [CW-1:0] cnt_nxt;
  reg ov_nxt;
  reg [CW-1:0] tot_nxt;
  reg [CW-1:0] free_nxt;
  always @* begin
    cnt_nxt = cnt_r + {{(CW-1){1'b0}}, wr_word} - {{(CW-1){1'b0}}, pop};
    ov_nxt = 1'b0;
    if (fall_through_select_r) begin
      ov_nxt = pop | (ov_r & ~rd_word);
    end
    tot_nxt = cnt_nxt + {{(CW-1){1'b0}}, ov_nxt};
    free_nxt = DEPTH_C - tot_nxt;
    if (fall_through_select_r) begin
      free_nxt = DEPTH_C + ONE_C - tot_nxt;
    end
  end

  always @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r <= {CW{1'b0}};
      ov_r <= 1'b0;
      wsub_r <= 2'h0;
      rsub_r <= 2'h0;
    end else if (!master_reset_n) begin
      cnt_r <= {CW{1'b0}};
      ov_r <= 1'b0;
      wsub_r <= 2'h0;
      rsub_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      if (wr_ok) begin
        wsub_r <= (wsub_r == wlast) ? 2'h0 : wsub_r + 2'h1;
      end
      if (rd_ok) begin
        rsub_r <= (rsub_r == rlast) ? 2'h0 : rsub_r + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag outputs
  wire ef_nxt = fall_through_select_r ? ~ov_nxt : (cnt_nxt == {CW{1'b0}});
  wire ff_nxt = (cnt_nxt == DEPTH_C);
  wire hf_nxt = (tot_nxt > HALF_C);
  wire ae_nxt = (tot_nxt < eofs_r);
  wire af_nxt = (free_nxt <= fofs_r);

  always @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      empty_flag_n <= 1'b0;
      full_flag_n <= 1'b1;
      half_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
    end else if (!master_reset_n) begin
      empty_flag_n <= fall_through_select;
      full_flag_n <= ~fall_through_select;
      half_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
    end else begin
      empty_flag_n <= fall_through_select_r ? ef_nxt : ~ef_nxt;
      full_flag_n <= fall_through_select_r ? ff_nxt : ~ff_nxt;
      half_full_flag_n <= ~hf_nxt;
      almost_empty_flag_n <= ~ae_nxt;
      almost_full_flag_n <= ~af_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events
  reg [`FRC_NEV-1:0] lvl_d_r;
  wire [`FRC_NEV-1:0] lvl;
  wire [`FRC_NEV-1:0] ev;
  reg [`FRC_NEV-1:0] ist_r;
  reg [`FRC_NEV-1:0] imsk_r;
  reg [`FRC_NEV-1:0] iclr;

  assign lvl[`FRC_EV_EMPTY] = (cnt_r == {CW{1'b0}}) & ~ov_r;
  assign lvl[`FRC_EV_FULL] = full_now;
  assign lvl[`FRC_EV_HALF] = ~half_full_flag_n;
  assign lvl[`FRC_EV_AEMP] = ~almost_empty_flag_n;
  assign lvl[`FRC_EV_AFUL] = ~almost_full_flag_n;
  assign lvl[`FRC_EV_DROP] = wr_try & full_now;
  assign lvl[`FRC_EV_MRS] = mrs_done;

  genvar gi;
  generate
    for (gi = 0; gi < `FRC_NEV; gi = gi + 1) begin : g_irq
      assign ev[gi] = lvl[gi] & (~lvl_d_r[gi] | gi >= `FRC_EV_DROP);
      always @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
          ist_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          ist_r[gi] <= 1'b1;
        end else if (iclr[gi]) begin
          ist_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lvl_d_r <= {`FRC_NEV{1'b1}};
      irq <= 1'b0;
    end else begin
      lvl_d_r <= lvl;
      irq <= |(ist_r & imsk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave
  reg wph_r;
  reg [7:0] wadr_r;
  reg [31:0] rd_mux;
  wire acc = hsel & htrans[1] & hready;

  always @* begin
    case (haddr[7:0])
      `FRC_CFG_OFS: rd_mux = {21'h000000, didx_r, rw_r, ww_r, pld_r,
                              par_r, bord_r, fall_through_select_r};
      `FRC_FLAG_OFS: rd_mux = {27'h0000000, almost_full_flag_n,
                               almost_empty_flag_n, half_full_flag_n,
                               full_flag_n, empty_flag_n};
      `FRC_EOFS_OFS: rd_mux = {{(32-CW){1'b0}}, eofs_r};
      `FRC_FOFS_OFS: rd_mux = {{(32-CW){1'b0}}, fofs_r};
      `FRC_IST_OFS: rd_mux = {{(32-`FRC_NEV){1'b0}}, ist_r};
      `FRC_IMSK_OFS: rd_mux = {{(32-`FRC_NEV){1'b0}}, imsk_r};
      `FRC_CNT_OFS: rd_mux = {{(31-CW){1'b0}}, ov_r, cnt_r};
      default: rd_mux = `FRC_RDATA_RST;
    endcase
  end

  always @* begin
    iclr = {`FRC_NEV{1'b0}};
    if (wph_r && wadr_r == `FRC_IST_OFS) begin
      iclr = hwdata[`FRC_NEV-1:0];
    end
  end

  always @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wph_r <= 1'b0;
      wadr_r <= 8'h00;
      hrdata <= `FRC_RDATA_RST;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      imsk_r <= `FRC_IMSK_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wph_r <= acc & hwrite;
      if (acc) begin
        wadr_r <= {haddr[7:2], 2'h0};
        hrdata <= hwrite ? `FRC_RDATA_RST : rd_mux;
      end
      if (wph_r && wadr_r == `FRC_IMSK_OFS) begin
        imsk_r <= hwdata[`FRC_NEV-1:0];
      end
    end
  end

endmodule // frc_top

// ==== testbench/frc_top_monitor.sv ====
// flag pin checks for frc_top
// assumes straps steady while master reset is low
`timescale 1ns/1ps
module frc_top_monitor (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // pins
  input wire master_reset_n,
  input wire width_match_enable,
  input wire input_width_select,
  input wire fall_through_select,
  input wire offset_access_enable_n,
  input wire serial_load_enable_n,
  input wire write_enable_n,
  input wire read_enable_n,
  // flags
  input wire empty_flag_n,
  input wire full_flag_n,
  input wire half_full_flag_n,
  input wire almost_empty_flag_n,
  input wire almost_full_flag_n
);
  reg [2:0] up_r;
  reg fall_through_select_r;
  reg wnar_r;
  wire live;
  assign live = (up_r == 3'h7);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      up_r <= 3'h0;
      fall_through_select_r <= 1'b0;
      wnar_r <= 1'b0;
    end else begin
      if (!live) up_r <= up_r + 3'h1;
      if (!master_reset_n) fall_through_select_r <= fall_through_select;
      if (!master_reset_n) wnar_r <= width_match_enable & input_width_select;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_mrs2;
    live && !master_reset_n ##1 !master_reset_n;
  endsequence
  sequence s_wr(bit ft);
    live && master_reset_n && fall_through_select_r == ft && !write_enable_n && !wnar_r &&
      offset_access_enable_n;
  endsequence
  AST_MRS_EF: assert property (s_mrs2 |->
    empty_flag_n == $past(fall_through_select) &&
    full_flag_n == !$past(fall_through_select))
    else $error("flags wrong in master reset");
  AST_MRS_LVL: assert property (s_mrs2 |->
    half_full_flag_n && !almost_empty_flag_n && almost_full_flag_n)
    else $error("level flags wrong in master reset");
  AST_EF_RISE: assert property (s_wr(0) ##0 !empty_flag_n |->
    ##[1:2] empty_flag_n) else $error("empty flag stuck");
  AST_FULL_HOLD: assert property (s_wr(0) ##0 !full_flag_n &&
    read_enable_n |=> !full_flag_n) else $error("full lost on drop");
  AST_OR_FALL: assert property (s_wr(1) ##0 empty_flag_n |->
    ##[1:4] !empty_flag_n) else $error("word not presented");
  AST_FULL_HALF: assert property (live && !fall_through_select_r && !full_flag_n |->
    !half_full_flag_n) else $error("full without half");
  AST_EF_IDLE: assert property (live && !fall_through_select_r && !empty_flag_n |->
    full_flag_n && half_full_flag_n) else $error("empty with words");
  AST_IR_SPACE: assert property (live && fall_through_select_r && empty_flag_n |->
    !full_flag_n) else $error("no space while idle");
  AST_SER_HOLD: assert property (live && master_reset_n &&
    $past(master_reset_n) && !fall_through_select_r && !offset_access_enable_n &&
    !serial_load_enable_n && write_enable_n && read_enable_n |=>
    $stable(empty_flag_n) && $stable(full_flag_n))
    else $error("serial load moved storage flags");
endmodule // frc_top_monitor

bind frc_top frc_top_monitor u_mon (.clk_sys, .resetn, .master_reset_n,
  .width_match_enable, .input_width_select,
  .fall_through_select, .offset_access_enable_n, .serial_load_enable_n,
  .write_enable_n, .read_enable_n, .empty_flag_n, .full_flag_n,
  .half_full_flag_n, .almost_empty_flag_n, .almost_full_flag_n);

// ==== testbench/frc_pins.sv ====
// writer and reader pin model
// assumes clk_sys shared with the block
`timescale 1ns/1ps
module frc_pins #(
  parameter int CW = 11
) (
  // clock
  input wire clk_sys,
  // straps and pins
  output logic master_reset_n,
  output logic [8:0] strap,
  output logic serial_load_enable_n,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic [35:0] write_data_in
);
  initial begin
    master_reset_n = 1'b1;
    strap = 9'h001;
    {serial_load_enable_n, write_enable_n, read_enable_n} = 3'h7;
    write_data_in = 36'h0;
  end
  // strap bit 0 doubles as load pin, bit 2 as serial input
  task automatic mreset(input logic [8:0] s);
    @(posedge clk_sys);
    master_reset_n <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk_sys);
    master_reset_n <= 1'b1;
    strap[0] <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic flip();
    @(posedge clk_sys);
    strap[8:3] <= ~strap[8:3];
    strap[1] <= ~strap[1];
  endtask
  task automatic wr(input int n, input logic [35:0] d, input logic ld_n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      write_enable_n <= 1'b0;
      strap[0] <= ld_n;
      write_data_in <= d + 36'(i);
    end
    @(posedge clk_sys);
    write_enable_n <= 1'b1;
    strap[0] <= 1'b1;
    write_data_in <= ~d;
  endtask
  task automatic rd();
    @(posedge clk_sys);
    read_enable_n <= 1'b0;
    @(posedge clk_sys);
    read_enable_n <= 1'b1;
  endtask
  task automatic ser(input logic [2*CW-1:0] v);
    for (int i = 2 * CW - 1; i >= 0; i--) begin
      @(posedge clk_sys);
      strap[0] <= 1'b0;
      serial_load_enable_n <= 1'b0;
      strap[2] <= v[i];
    end
    @(posedge clk_sys);
    strap[0] <= 1'b1;
    serial_load_enable_n <= 1'b1;
    strap[2] <= ~v[0];
  endtask
endmodule // frc_pins

// ==== testbench/tb_top.sv ====
// self-checking bench for frc_top
// assumes DEPTH 16, CW 11 and the frc_pins model
`timescale 1ns/1ps
module tb_top;
  localparam int CW = 11;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, mrs_n, sen_n, we_n, re_n;
  wire ef, ff, hf, ae, af;
  wire [8:0] s;
  wire [35:0] wd;
  int fails = 0;
  int compares = 0;
  always #4 clk_sys = ~clk_sys;
  frc_top #(.DEPTH(16), .CW(CW)) uut (.clk_sys, .resetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .master_reset_n(mrs_n), .width_match_enable(s[8]),
    .input_width_select(s[7]), .output_width_select(s[6]),
    .byte_order_select(s[5]), .default_offset_sel_lo(s[4]),
    .default_offset_sel_hi(s[3]), .fall_through_select(s[2]),
    .parity_placement_select(s[1]), .offset_access_enable_n(s[0]),
    .serial_load_enable_n(sen_n), .write_enable_n(we_n),
    .read_enable_n(re_n), .write_data_in(wd), .empty_flag_n(ef),
    .full_flag_n(ff), .half_full_flag_n(hf), .almost_empty_flag_n(ae),
    .almost_full_flag_n(af), .irq);
  frc_pins #(.CW(CW)) ptn (.clk_sys, .master_reset_n(mrs_n), .strap(s),
    .serial_load_enable_n(sen_n), .write_enable_n(we_n),
    .read_enable_n(re_n), .write_data_in(wd));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) n = 99;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 99);
    r = hrdata;
    if (hreadyout !== 1'b1 || n > 99) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e, input string nm);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(nm, e, v & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask
  // mask and expected value over {ef, ff, hf, ae, af}
  task automatic flags(input logic [4:0] m, input logic [4:0] e);
    repeat (4) @(posedge clk_sys);
    chk("flags", {27'h0, e}, {27'h0, m & {ef, ff, hf, ae, af}});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    logic [2:0] wm [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [3:0] wc [5] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h2};
    logic [2:0] b;
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      b = k[2:0];
      ptn.mreset({wm[k % 5], b[0], b[0], b[1], b[2], b[1], b[2]});
      e = {21'h0, b, wc[k % 5], ~b[2], b[1], b[0], b[2]};
      rdchk(8'h00, 32'h7ff, e, "cfg");
      rdchk(8'h08, 32'h7ff, (32'h1 << (k + 3)) - 32'h1, "eofs");
      rdchk(8'h0c, 32'h7ff, (32'h1 << (k + 3)) - 32'h1, "fofs");
      ptn.flip();
      rdchk(8'h00, 32'h7ff, e, "cfg held");
    end
  endtask
  task automatic t_std();
    ptn.mreset(9'h001);
    wreg(8'h14, 32'h0);
    wreg(8'h10, 32'h7f);
    ptn.wr(8, 36'h0, 1'b1);
    flags(5'h1c, 5'h1c);
    ptn.wr(1, 36'h8, 1'b1);
    flags(5'h1c, 5'h18);
    ptn.wr(7, 36'h9, 1'b1);
    flags(5'h1f, 5'h10);
    ptn.wr(1, 36'h1, 1'b1);
    rdchk(8'h18, 32'h7ff, 32'd16, "count");
    rdchk(8'h10, 32'h20, 32'h20, "drop");
    chk("irq", 32'h0, {31'h0, irq});
    wreg(8'h14, 32'h20);
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    wreg(8'h10, 32'h20);
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    rdchk(8'h1c, 32'hffffffff, 32'h0, "unmapped");
    repeat (16) ptn.rd();
    flags(5'h1f, 5'h0c);
  endtask
  task automatic t_fall_through_select();
    ptn.mreset(9'h005);
    flags(5'h18, 5'h10);
    ptn.wr(1, 36'h0, 1'b1);
    flags(5'h10, 5'h00);
    ptn.wr(16, 36'h10, 1'b1);
    flags(5'h18, 5'h08);
    repeat (17) ptn.rd();
    flags(5'h18, 5'h10);
  endtask
  task automatic t_ser();
    ptn.mreset(9'h001);
    ptn.ser({11'd3, 11'd5});
    flags(5'h10, 5'h00);
    rdchk(8'h08, 32'h7ff, 32'd3, "eofs");
    rdchk(8'h0c, 32'h7ff, 32'd5, "fofs");
    ptn.wr(2, 36'h0, 1'b1);
    flags(5'h02, 5'h00);
    ptn.wr(1, 36'h2, 1'b1);
    flags(5'h03, 5'h03);
    ptn.wr(8, 36'h3, 1'b1);
    flags(5'h01, 5'h00);
  endtask
  task automatic t_par();
    logic [31:0] ee [3] = '{32'h705, 32'h305, 32'h105};
    logic [31:0] fe [3] = '{32'h203, 32'h103, 32'h003};
    for (int p = 0; p < 3; p++) begin
      ptn.mreset({(p == 2) ? 3'h7 : 3'h0, 4'h0, p[0], 1'b0});
      ptn.wr(1, 36'hf00000705, 1'b0);
      ptn.wr(1, 36'hf00000203, 1'b0);
      flags(5'h10, 5'h00);
      rdchk(8'h08, 32'h7ff, ee[p], "eofs");
      rdchk(8'h0c, 32'h7ff, fe[p], "fofs");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_cfg();
    t_std();
    t_fall_through_select();
    t_ser();
    t_par();
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule // tb_top
